// [logic/cfp_config_flash_programmer.v]
// Contract
// R1: Status bit 0 reads 1 when FPGA configuration is done.
// R2: Status bit 1 mirrors the FPGA clear-done line.
// R3: Control bit 0 high suspends automatic loading from flash.
// R4: Writing 1 to control bit 2 resets FPGA configuration logic.
// R5: Each configuration data write sends one byte to the FPGA port.
// R6: Host sets stop bit before writing configuration data.
// R7: Host clears the FPGA configuration before loading a new one.
// R8: Fault status bit 5 mirrors the flash fault output.
// R9: Busy status bit 7 reads 1 while flash busy; others zero.
// R10: Busy reads 1 whenever the stop bit is 0.
// R11: Host checks busy is 0 before any new flash command.
// R12: Reading the flash read register reads flash at the held address.
// R13: Flash reset command returns flash to array read, even while busy; the code drops a reset that arrives during the strobe pulse.
// R14: Program command writes the held byte at the held address.
// R15: Held address increments by one after each program completes.
// R16: Sector erase selects sector from top seven address bits.
// R17: Chip erase clears whole flash; busy falls on completion.
// R18: Commands are ignored during erase; hardware reset aborts it.
// R19: Host erases before reprogramming any flash area.
// R20: Data register holds program byte in low 8 bits; any access width.
// R21: Three byte registers form the 24-bit flash address.
// R22: Monitor data access reaches the register chosen by monitor address.
// R23: A byte program keeps busy about 9 microseconds.
// R24: Busy rises at command issue and falls on flash ready; the code drops it for a read at strobe end.
`timescale 1ns/1ns
`include "cfp_consts.vh"
module cfp_config_flash_programmer #(
    parameter PROG_CYCLES = `CFP_PROG_CYCLES
) (
    input  wire        clk,
    input  wire        srst,
    input  wire        clkEn,
    input  wire        regWr,
    input  wire        regRd,
    input  wire [14:0] regAddr,
    input  wire [3:0]  regBe,
    input  wire [31:0] regWdata,
    output reg  [31:0] regRdata_r,
    output reg         regRvalid_r,
    input  wire        fpgaDonePin,
    input  wire        fpgaClearDonePin,
    output wire        cfgStop,
    output reg         cfgClear_r,
    output reg  [7:0]  cfgByte_r,
    output reg         cfgByteStrobe_r,
    input  wire        flashReadyPin,
    input  wire [7:0]  flashDqPin,
    output wire [23:0] flashAddrOut,
    output wire [7:0]  flashDataOut,
    output wire [2:0]  flashOp,
    output wire        flashStrobe,
    output reg  [6:0]  monAddr_r,
    output reg  [15:0] monWdata_r,
    output reg         monWrite_r,
    input  wire [15:0] monRdata
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg [1:0] doneSync_r;
    reg [1:0] clrSync_r;
    reg [1:0] rdySync_r;
    reg [7:0] dqMeta_r;
    reg [7:0] dqSync_r;
    reg [15:0] monMeta_r;
    reg [15:0] monSync_r;
    always @(posedge clk) begin
        if (srst) begin
            doneSync_r <= 2'b00;
            clrSync_r  <= 2'b00;
            rdySync_r  <= 2'b00;
            dqMeta_r   <= 8'h00;
            dqSync_r   <= 8'h00;
            monMeta_r  <= 16'h0000;
            monSync_r  <= 16'h0000;
        end else if (clkEn) begin
            doneSync_r <= {doneSync_r[0], fpgaDonePin};
            clrSync_r  <= {clrSync_r[0], fpgaClearDonePin};
            rdySync_r  <= {rdySync_r[0], flashReadyPin};
            dqMeta_r   <= flashDqPin;
            dqSync_r   <= dqMeta_r;
            monMeta_r  <= monRdata;
            monSync_r  <= monMeta_r;
        end
    end

    // ****************************************
    // Byte merge for sub-word writes
    // ****************************************
    // Only lane 0 matters for byte registers; upper lanes are dropped.
    function [7:0] lowLane;
        input [7:0] old;
        input [3:0] be;
        input [31:0] wd;
        begin
            lowLane = be[0] ? wd[7:0] : old;
        end
    endfunction

    wire hit0 = regBe[0];
    wire wrCtl  = regWr && regAddr == `CFP_OFF_CONTROL;
    wire wrCfg  = regWr && regAddr == `CFP_OFF_CFGDATA && hit0;
    wire wrRst  = regWr && regAddr == `CFP_OFF_RESET   && hit0 && regWdata[`CFP_BIT_CMD];
    wire wrProg = regWr && regAddr == `CFP_OFF_PROGRAM && hit0 && regWdata[`CFP_BIT_CMD];
    wire wrSect = regWr && regAddr == `CFP_OFF_SECTOR  && hit0 && regWdata[`CFP_BIT_CMD];
    wire wrChip = regWr && regAddr == `CFP_OFF_CHIP    && hit0 && regWdata[`CFP_BIT_CMD];
    wire rdFlash = regRd && regAddr == `CFP_OFF_READ;

    // ****************************************
    // Registers
    // ****************************************
    reg [7:0] control_r;
    reg [7:0] wByte_r;
    reg [7:0] addrL_r;
    reg [7:0] addrM_r;
    reg [7:0] addrH_r;
    reg       readPending_r;
    wire      seqBusy;
    wire      eraseActive;
    wire      progDone;
    wire      readValid;
    wire [7:0] readByte;

    assign cfgStop = control_r[`CFP_BIT_STOP]; // R3

    // Erase blocks every new command; only reset passes while a non-erase op hangs busy.
    wire acceptCmd = !eraseActive && (!seqBusy || wrRst); // R18
    wire goRead  = rdFlash && acceptCmd && !seqBusy;
    wire goRst   = wrRst && !eraseActive; // R13
    wire goProg  = wrProg && acceptCmd && !seqBusy;
    wire goSect  = wrSect && acceptCmd && !seqBusy;
    wire goChip  = wrChip && acceptCmd && !seqBusy;

    wire [23:0] addrNext = {addrH_r, addrM_r, addrL_r} + 24'h000001;

    always @(posedge clk) begin
        if (srst) begin
            control_r       <= `CFP_RST_CONTROL;
            cfgClear_r      <= 1'b0;
            cfgByte_r       <= `CFP_RST_BYTE;
            cfgByteStrobe_r <= 1'b0;
            wByte_r         <= `CFP_RST_BYTE;
            addrL_r         <= `CFP_RST_BYTE;
            addrM_r         <= `CFP_RST_BYTE;
            addrH_r         <= `CFP_RST_BYTE;
            monAddr_r       <= 7'h00;
            monWdata_r      <= 16'h0000;
            monWrite_r      <= 1'b0;
        end else if (clkEn) begin
            cfgByteStrobe_r <= 1'b0;
            monWrite_r      <= 1'b0;
            cfgClear_r      <= 1'b0;
            if (wrCtl && hit0) begin
                control_r <= {7'h00, regWdata[`CFP_BIT_STOP]}; // R3
                cfgClear_r <= regWdata[`CFP_BIT_CLEAR]; // R4
            end
            if (wrCfg) begin
                cfgByte_r       <= regWdata[7:0]; // R5
                cfgByteStrobe_r <= 1'b1; // R5
            end
            if (regWr && regAddr == `CFP_OFF_WDATA) begin
                wByte_r <= lowLane(wByte_r, regBe, regWdata); // R20
            end
            if (progDone) begin
                {addrH_r, addrM_r, addrL_r} <= addrNext; // R15
            end else begin
                if (regWr && regAddr == `CFP_OFF_ADDRL) begin
                    addrL_r <= lowLane(addrL_r, regBe, regWdata); // R21
                end
                if (regWr && regAddr == `CFP_OFF_ADDRM) begin
                    addrM_r <= lowLane(addrM_r, regBe, regWdata); // R21
                end
                if (regWr && regAddr == `CFP_OFF_ADDRH) begin
                    addrH_r <= lowLane(addrH_r, regBe, regWdata); // R21
                end
            end
            if (regWr && regAddr == `CFP_OFF_MONADDR && regBe[2]) begin
                monAddr_r <= regWdata[22:16]; // R22
            end
            if (regWr && regAddr == `CFP_OFF_MONDATA) begin
                monWdata_r <= regWdata[15:0]; // R22
                monWrite_r <= 1'b1; // R22
            end
        end
    end

    // ****************************************
    // Flash sequencer
    // ****************************************
    cfp_flash_seq #(
        .PROG_CYCLES (PROG_CYCLES)
    ) uSeq (
        .clk           (clk),
        .srst          (srst),
        .clkEn         (clkEn),
        .cmdRead       (goRead),
        .cmdReset      (goRst),
        .cmdProgram    (goProg),
        .cmdSector     (goSect),
        .cmdChip       (goChip),
        .addrIn        ({addrH_r, addrM_r, addrL_r}),
        .dataIn        (wByte_r),
        .flashReadyS   (rdySync_r[1]),
        .flashDqS      (dqSync_r),
        .busy_r        (seqBusy),
        .eraseActive_r (eraseActive),
        .progDone_r    (progDone),
        .readValid_r   (readValid),
        .readByte_r    (readByte),
        .flashAddr_r   (flashAddrOut),
        .flashDout_r   (flashDataOut),
        .flashOp_r     (flashOp),
        .flashStrobe_r (flashStrobe)
    );

    // ****************************************
    // Read path
    // ****************************************
    // An accepted flash read answers late, once the sequencer samples the bus; a refused flash read (zero) and others answer next cycle.
    wire flashBusyBit = seqBusy | ~control_r[`CFP_BIT_STOP]; // R10
    reg [31:0] rdMux;
    always @* begin
        rdMux = 32'h00000000;
        case (regAddr)
            `CFP_OFF_STATUS:  rdMux = {30'h0, clrSync_r[1], doneSync_r[1]}; // R1 R2
            `CFP_OFF_CONTROL: rdMux = {24'h0, control_r};
            `CFP_OFF_FAULT:   rdMux = {26'h0, dqSync_r[`CFP_BIT_FAULT], 5'h00}; // R8
            `CFP_OFF_BUSY:    rdMux = {24'h0, flashBusyBit, 7'h00}; // R9
            `CFP_OFF_WDATA:   rdMux = {24'h0, wByte_r};
            `CFP_OFF_ADDRL:   rdMux = {24'h0, addrL_r};
            `CFP_OFF_ADDRM:   rdMux = {24'h0, addrM_r};
            `CFP_OFF_ADDRH:   rdMux = {24'h0, addrH_r};
            `CFP_OFF_MONDATA: rdMux = {9'h000, monAddr_r, monSync_r}; // R22
            default:          rdMux = 32'h00000000;
        endcase
    end

    always @(posedge clk) begin
        if (srst) begin
            regRdata_r    <= 32'h00000000;
            regRvalid_r   <= 1'b0;
            readPending_r <= 1'b0;
        end else if (clkEn) begin
            regRvalid_r <= 1'b0;
            if (readValid && readPending_r) begin
                regRdata_r    <= {24'h0, readByte}; // R12
                regRvalid_r   <= 1'b1;
                readPending_r <= 1'b0;
            end else if (rdFlash) begin
                if (goRead) begin
                    readPending_r <= 1'b1; // R12
                end else begin
                    regRdata_r  <= 32'h00000000;
                    regRvalid_r <= 1'b1;
                end
            end else if (regRd) begin
                regRdata_r  <= rdMux;
                regRvalid_r <= 1'b1;
            end
        end
    end
endmodule

// [logic/cfp_consts.vh]
`ifndef CFP_CONSTS_VH
`define CFP_CONSTS_VH
`define CFP_OFF_STATUS      15'h0000
`define CFP_OFF_CONTROL     15'h0004
`define CFP_OFF_CFGDATA     15'h0008
`define CFP_OFF_FAULT       15'h000c
`define CFP_OFF_BUSY        15'h0010
`define CFP_OFF_READ        15'h0014
`define CFP_OFF_RESET       15'h0018
`define CFP_OFF_PROGRAM     15'h001c
`define CFP_OFF_SECTOR      15'h0020
`define CFP_OFF_CHIP        15'h0024
`define CFP_OFF_WDATA       15'h0028
`define CFP_OFF_ADDRL       15'h002c
`define CFP_OFF_ADDRM       15'h0030
`define CFP_OFF_ADDRH       15'h0034
`define CFP_OFF_MONDATA     15'h0038
`define CFP_OFF_MONADDR     15'h003c
`define CFP_BIT_DONE        0
`define CFP_BIT_CLEARDONE   1
`define CFP_BIT_STOP        0
`define CFP_BIT_CLEAR       2
`define CFP_BIT_FAULT       5
`define CFP_BIT_BUSY        7
`define CFP_BIT_CMD         0
`define CFP_RST_CONTROL     8'h01
`define CFP_RST_BYTE        8'h00
`define CFP_PROG_TIME_NS    9000
`define CFP_CLK_PERIOD_NS   100
`define CFP_PROG_CYCLES     ((`CFP_PROG_TIME_NS + `CFP_CLK_PERIOD_NS - 1) / `CFP_CLK_PERIOD_NS)
`define CFP_STROBE_CYCLES   4
`endif

// [logic/cfp_flash_seq.v]
`timescale 1ns/1ns
`include "cfp_consts.vh"
module cfp_flash_seq #(
    parameter PROG_CYCLES = `CFP_PROG_CYCLES
) (
    input  wire        clk,
    input  wire        srst,
    input  wire        clkEn,
    input  wire        cmdRead,
    input  wire        cmdReset,
    input  wire        cmdProgram,
    input  wire        cmdSector,
    input  wire        cmdChip,
    input  wire [23:0] addrIn,
    input  wire [7:0]  dataIn,
    input  wire        flashReadyS,
    input  wire [7:0]  flashDqS,
    output reg         busy_r,
    output reg         eraseActive_r,
    output reg         progDone_r,
    output reg         readValid_r,
    output reg  [7:0]  readByte_r,
    output reg  [23:0] flashAddr_r,
    output reg  [7:0]  flashDout_r,
    output reg  [2:0]  flashOp_r,
    output reg         flashStrobe_r
);
    // ********************************
    // Sequencer states
    // ********************************
    localparam ST_IDLE  = 2'd0;
    localparam ST_PULSE = 2'd1;
    localparam ST_WAIT  = 2'd2;
    localparam ST_MIN   = 2'd3;
    localparam OP_READ  = 3'd1;
    localparam OP_RESET = 3'd2;
    localparam OP_PROG  = 3'd3;
    localparam OP_SECT  = 3'd4;
    localparam OP_CHIP  = 3'd5;
    reg [1:0]  state_r;
    reg [15:0] cnt_r;
    wire anyCmd = cmdRead | cmdReset | cmdProgram | cmdSector | cmdChip;
    always @(posedge clk) begin
        if (srst) begin
            state_r       <= ST_IDLE;
            cnt_r         <= 16'h0000;
            busy_r        <= 1'b0;
            eraseActive_r <= 1'b0;
            progDone_r    <= 1'b0;
            readValid_r   <= 1'b0;
            readByte_r    <= 8'h00;
            flashAddr_r   <= 24'h000000;
            flashDout_r   <= 8'h00;
            flashOp_r     <= 3'd0;
            flashStrobe_r <= 1'b0;
        end else if (clkEn) begin
            progDone_r  <= 1'b0;
            readValid_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (anyCmd) begin
                        busy_r        <= 1'b1; // R24
                        flashAddr_r   <= addrIn; // R12
                        flashDout_r   <= dataIn; // R14
                        flashStrobe_r <= 1'b1;
                        cnt_r         <= 16'h0000;
                        state_r       <= ST_PULSE;
                        if (cmdReset) begin
                            flashOp_r <= OP_RESET; // R13
                        end else if (cmdChip) begin
                            flashOp_r     <= OP_CHIP; // R17
                            eraseActive_r <= 1'b1;
                        end else if (cmdSector) begin
                            flashOp_r     <= OP_SECT; // R16
                            eraseActive_r <= 1'b1;
                            flashAddr_r   <= {addrIn[23:17], 17'h00000}; // R16
                        end else if (cmdProgram) begin
                            flashOp_r <= OP_PROG; // R14
                        end else begin
                            flashOp_r <= OP_READ; // R12
                        end
                    end
                end
                ST_PULSE: begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r == `CFP_STROBE_CYCLES - 1) begin
                        flashStrobe_r <= 1'b0;
                        if (flashOp_r == OP_READ) begin
                            readByte_r  <= flashDqS;
                            readValid_r <= 1'b1;
                            busy_r      <= 1'b0;
                            state_r     <= ST_IDLE;
                        end else begin
                            state_r <= (flashOp_r == OP_PROG) ? ST_MIN : ST_WAIT;
                        end
                    end
                end
                ST_MIN: begin
                    // Programming holds busy at least the nominal byte time even if ready returns early.
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r >= PROG_CYCLES[15:0]) begin // R23
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (flashReadyS) begin // R24
                        busy_r        <= 1'b0;
                        eraseActive_r <= 1'b0; // R18
                        progDone_r    <= (flashOp_r == OP_PROG); // R15
                        state_r       <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
            if (cmdReset && state_r[1]) begin
                busy_r        <= 1'b1;
                flashOp_r     <= OP_RESET; // R13
                flashStrobe_r <= 1'b1;
                cnt_r         <= 16'h0000;
                state_r       <= ST_PULSE;
            end
        end
    end
endmodule

// [test/cfp_config_flash_programmer_chk.sv]
`timescale 1ns/1ns
`include "cfp_consts.vh"
// ****************
// Port checker
// ****************
module cfp_config_flash_programmer_chk #(
    parameter PROG_CYCLES = 4
) (
    input wire        clk,
    input wire        srst,
    input wire        regWr,
    input wire        regRd,
    input wire [14:0] regAddr,
    input wire [3:0]  regBe,
    input wire [31:0] regWdata,
    input wire        regRvalid_r,
    input wire        cfgStop,
    input wire        cfgClear_r,
    input wire [7:0]  cfgByte_r,
    input wire        cfgByteStrobe_r,
    input wire [23:0] flashAddrOut,
    input wire [2:0]  flashOp,
    input wire        flashStrobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire ctlWr = regWr && regAddr == `CFP_OFF_CONTROL && regBe[0];
    wire datWr = regWr && regAddr == `CFP_OFF_CFGDATA && regBe[0];
    wire flRd  = regRd && regAddr == `CFP_OFF_READ;
    sequence s_strobe;
        flashStrobe [*4] ##1 !flashStrobe;
    endsequence
    a_strobe_len: assert property ($rose(flashStrobe) |-> s_strobe)
        else $error("strobe length wrong");
    a_strobe_cause: assert property ($rose(flashStrobe) |-> $past(regWr || regRd))
        else $error("strobe without access");
    a_sector_addr: assert property ($rose(flashStrobe) && flashOp == 3'h4 |-> flashAddrOut[16:0] == 17'h0)
        else $error("sector address low bits set");
    a_read_answer: assert property (regRd && !flRd |=> regRvalid_r)
        else $error("read not answered");
    a_flash_read: assert property (flRd |-> ##[1:8] regRvalid_r)
        else $error("flash read not answered");
    a_clear_pulse: assert property (ctlWr && regWdata[2] |=> cfgClear_r ##1 !cfgClear_r)
        else $error("clear pulse wrong");
    a_clear_none: assert property (ctlWr && !regWdata[2] |=> !cfgClear_r)
        else $error("clear without request");
    a_stop_bit: assert property (ctlWr |=> cfgStop == $past(regWdata[0]))
        else $error("stop bit wrong");
    a_cfg_byte: assert property (datWr |=> cfgByteStrobe_r && cfgByte_r == $past(regWdata[7:0]))
        else $error("config byte wrong");
endmodule
bind cfp_config_flash_programmer cfp_config_flash_programmer_chk #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
    .clk(clk), .srst(srst), .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regBe(regBe),
    .regWdata(regWdata), .regRvalid_r(regRvalid_r), .cfgStop(cfgStop), .cfgClear_r(cfgClear_r),
    .cfgByte_r(cfgByte_r), .cfgByteStrobe_r(cfgByteStrobe_r), .flashAddrOut(flashAddrOut),
    .flashOp(flashOp), .flashStrobe(flashStrobe));

// [test/cfp_flash_model.sv]
`timescale 1ns/1ns
// ****************
// Flash model
// ****************
module cfp_flash_model (
    input  wire        clk,
    input  wire [23:0] flashAddrOut,
    input  wire [7:0]  flashDataOut,
    input  wire [2:0]  flashOp,
    input  wire        flashStrobe,
    input  wire        fault,
    output wire        flashReadyPin,
    output wire [7:0]  flashDqPin
);
    reg [7:0]  mem [0:255];
    reg [23:0] lastAddr = 24'h0;
    reg [2:0]  lastOp   = 3'h0;
    reg [7:0]  rdByte   = 8'h00;
    reg [7:0]  pat      = 8'h00;
    reg        strQ     = 1'b0;
    integer    busyCnt  = 0;
    integer    holdCnt  = 0;
    integer    nCmd     = 0;
    integer    i;
    initial for (i = 0; i < 256; i = i + 1) mem[i] = 8'h00;
    assign flashReadyPin = (busyCnt == 0);
    // Outside a read the lines move every cycle, so a stale sample cannot pass.
    assign flashDqPin = (holdCnt > 0) ? rdByte : {pat[7:6], fault, pat[4:0]};
    always @(posedge clk) begin
        strQ <= flashStrobe;
        pat <= pat + 8'h25;
        if (busyCnt > 0) busyCnt <= busyCnt - 1;
        if (holdCnt > 0) holdCnt <= holdCnt - 1;
        if (flashStrobe && !strQ) begin
            nCmd <= nCmd + 1;
            lastOp <= flashOp;
            lastAddr <= flashAddrOut;
            case (flashOp)
                3'h1: begin
                    rdByte <= mem[flashAddrOut[7:0]];
                    holdCnt <= 10;
                end
                3'h2: busyCnt <= 3;
                3'h3: begin
                    mem[flashAddrOut[7:0]] <= mem[flashAddrOut[7:0]] & flashDataOut;
                    busyCnt <= 20;
                end
                3'h4, 3'h5: begin
                    for (i = 0; i < 256; i = i + 1) mem[i] <= 8'hff;
                    busyCnt <= 60;
                end
                default: ;
            endcase
        end
    end
endmodule

// [test/tb_cfp_config_flash_programmer.sv]
`timescale 1ns/1ns
`include "cfp_consts.vh"
// ****************
// Testbench
// ****************
module tb_cfp_config_flash_programmer;
    reg         clk      = 1'b0;
    reg         srst     = 1'b1;
    reg         regWr    = 1'b0;
    reg         regRd    = 1'b0;
    reg  [14:0] regAddr  = 15'h0000;
    reg  [3:0]  regBe    = 4'h0;
    reg  [31:0] regWdata = 32'h0;
    reg         doneP    = 1'b0;
    reg         clrP     = 1'b0;
    reg         fault    = 1'b0;
    reg  [15:0] monRdata = 16'h0;
    wire [31:0] regRdata_r;
    wire        regRvalid_r, cfgStop, cfgClear_r, cfgByteStrobe_r, flashReadyPin, flashStrobe;
    wire [7:0]  cfgByte_r, flashDqPin, flashDataOut;
    wire [23:0] flashAddrOut;
    wire [2:0]  flashOp;
    wire [6:0]  monAddr_r;
    wire [15:0] monWd;
    reg  [63:0] notes [$];
    reg  [63:0] nt;
    reg  [31:0] lastRd   = 32'h0;
    reg  [31:0] d;
    reg  [23:0] a;
    reg  [14:0] ad;
    reg  [7:0]  b0;
    integer     error_cnt = 0;
    integer     n_tests   = 0;
    integer     nRx       = 0;
    integer     n0, k;
    cfp_config_flash_programmer #(.PROG_CYCLES(4)) i_dut (
        .clk(clk), .srst(srst), .clkEn(1'b1), .regWr(regWr), .regRd(regRd), .regAddr(regAddr),
        .regBe(regBe), .regWdata(regWdata), .regRdata_r(regRdata_r), .regRvalid_r(regRvalid_r),
        .fpgaDonePin(doneP), .fpgaClearDonePin(clrP), .cfgStop(cfgStop), .cfgClear_r(cfgClear_r),
        .cfgByte_r(cfgByte_r), .cfgByteStrobe_r(cfgByteStrobe_r), .flashReadyPin(flashReadyPin),
        .flashDqPin(flashDqPin), .flashAddrOut(flashAddrOut), .flashDataOut(flashDataOut), .flashOp(flashOp),
        .flashStrobe(flashStrobe), .monAddr_r(monAddr_r), .monWdata_r(monWd), .monWrite_r(), .monRdata(monRdata));
    cfp_flash_model i_flash (.clk(clk), .flashAddrOut(flashAddrOut), .flashDataOut(flashDataOut),
        .flashOp(flashOp), .flashStrobe(flashStrobe), .fault(fault), .flashReadyPin(flashReadyPin),
        .flashDqPin(flashDqPin));
    initial forever #50 clk = ~clk;
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task print_verdict;
        begin
            if (error_cnt == 0 && n_tests > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // Answers are taken at the falling edge, where the one-cycle valid pulse has settled.
    always @(negedge clk) begin
        if (regRvalid_r === 1'b1) begin
            lastRd = regRdata_r;
            nRx = nRx + 1;
            if (notes.size() > 0) begin
                nt = notes.pop_front();
                check(regRdata_r & nt[63:32], nt[31:0]);
            end
        end
    end
    task wr(input [14:0] wa, input [3:0] be, input [31:0] wd);
        begin
            @(negedge clk);
            regWr = 1'b1;
            regAddr = wa;
            regBe = be;
            regWdata = wd;
            @(negedge clk);
            regWr = 1'b0;
        end
    endtask
    task rd(input [14:0] ra);
        integer j, m0;
        begin
            m0 = nRx;
            @(negedge clk);
            regRd = 1'b1;
            regAddr = ra;
            @(negedge clk);
            regRd = 1'b0;
            for (j = 0; j < 20 && nRx == m0; j = j + 1) @(negedge clk);
            if (nRx == m0) check(32'h0, 32'h1);
        end
    endtask
    task chk(input [14:0] ca, input [31:0] ex, input [31:0] mk);
        begin
            notes.push_back({mk, ex & mk});
            rd(ca);
        end
    endtask
    task idle;
        integer j;
        begin
            lastRd = 32'h80;
            for (j = 0; j < 100 && lastRd[7] !== 1'b0; j = j + 1) rd(`CFP_OFF_BUSY);
            check(lastRd & 32'h80, 32'h0);
        end
    endtask
    task setA(input [23:0] av);
        begin
            wr(`CFP_OFF_ADDRL, 4'h1, {24'h0, av[7:0]});
            wr(`CFP_OFF_ADDRM, 4'h1, {24'h0, av[15:8]});
            wr(`CFP_OFF_ADDRH, 4'h1, {24'h0, av[23:16]});
        end
    endtask
    initial begin
        #3000000;
        error_cnt = error_cnt + 1;
        print_verdict;
    end
    initial begin
        k = $urandom(32'h8101d61a);
        repeat (2) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        chk(`CFP_OFF_STATUS, 32'h0, 32'hff);
        chk(`CFP_OFF_CONTROL, 32'h1, 32'hff);
        chk(`CFP_OFF_BUSY, 32'h0, 32'hff);
        chk(15'h0040, 32'h0, 32'hffffffff);
        wr(`CFP_OFF_CONTROL, 4'h1, 32'h0);
        chk(`CFP_OFF_BUSY, 32'h80, 32'hff);
        wr(`CFP_OFF_CONTROL, 4'h1, 32'h5);
        chk(`CFP_OFF_CONTROL, 32'h1, 32'h3);
        doneP = 1'b1;
        repeat (4) @(negedge clk);
        chk(`CFP_OFF_STATUS, 32'h1, 32'hff);
        doneP = 1'b0;
        clrP = 1'b1;
        repeat (4) @(negedge clk);
        chk(`CFP_OFF_STATUS, 32'h2, 32'hff);
        for (k = 0; k < 3; k = k + 1) wr(`CFP_OFF_CFGDATA, 4'h1, $urandom);
        for (k = 0; k < 4; k = k + 1) begin
            d = $urandom;
            ad = `CFP_OFF_WDATA + 15'h4 * k[14:0];
            wr(ad, k[0] ? 4'h1 : (k[1] ? 4'h3 : 4'hf), d);
            // A write without the low byte lane must leave the register alone.
            wr(ad, 4'he, ~d);
            chk(ad, d, 32'hff);
        end
        wr(`CFP_OFF_CHIP, 4'h1, 32'h1);
        idle;
        check(i_flash.mem[8'h10], 32'hff);
        d = $urandom;
        a = {d[15:0], 8'h10};
        setA(a);
        for (k = 0; k < 2; k = k + 1) begin
            d = $urandom;
            if (k == 0) b0 = d[7:0];
            wr(`CFP_OFF_WDATA, 4'h1, d);
            wr(`CFP_OFF_PROGRAM, 4'h1, 32'h1);
            chk(`CFP_OFF_BUSY, 32'h80, 32'hff);
            n0 = i_flash.nCmd;
            wr(`CFP_OFF_PROGRAM, 4'h1, 32'h1);
            idle;
            check(i_flash.nCmd, n0);
            check(i_flash.mem[a[7:0] + k[7:0]], d[7:0]);
            check(i_flash.lastAddr, a + k[23:0]);
        end
        chk(`CFP_OFF_ADDRL, a[7:0] + 8'h2, 32'hff);
        setA(a);
        chk(`CFP_OFF_READ, b0, 32'hff);
        wr(`CFP_OFF_PROGRAM, 4'h1, 32'h1);
        repeat (6) @(negedge clk);
        wr(`CFP_OFF_RESET, 4'h1, 32'h1);
        repeat (3) @(negedge clk);
        check(i_flash.lastOp, 3'h2);
        idle;
        d = $urandom;
        a = d[23:0];
        setA(a);
        wr(`CFP_OFF_SECTOR, 4'h1, 32'h1);
        repeat (6) @(negedge clk);
        n0 = i_flash.nCmd;
        wr(`CFP_OFF_RESET, 4'h1, 32'h1);
        idle;
        check(i_flash.nCmd, n0);
        check(i_flash.lastAddr, {a[23:17], 17'h0});
        fault = 1'b1;
        repeat (4) @(negedge clk);
        chk(`CFP_OFF_FAULT, 32'h20, 32'h20);
        fault = 1'b0;
        repeat (4) @(negedge clk);
        chk(`CFP_OFF_FAULT, 32'h0, 32'h20);
        d = $urandom;
        monRdata = d[15:0];
        wr(`CFP_OFF_MONADDR, 4'h4, 32'h00210000);
        check(monAddr_r, 32'h21);
        chk(`CFP_OFF_MONDATA, {9'h0, 7'h21, monRdata}, 32'h007fffff);
        wr(`CFP_OFF_MONDATA, 4'hf, d);
        check(monWd, d[15:0]);
        wr(`CFP_OFF_CHIP, 4'h1, 32'h1);
        repeat (6) @(negedge clk);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk(`CFP_OFF_BUSY, 32'h0, 32'hff);
        chk(`CFP_OFF_CONTROL, 32'h1, 32'hff);
        print_verdict;
    end
endmodule
